//--- src/oag_pkg.sv
// Shared constants and carrier types for operand address generation
package oag_pkg;
  // ****************************************
  // Register codes and pairs
  // ****************************************
  localparam logic [2:0] REG_X = 3'h0;
  localparam logic [2:0] REG_A = 3'h1;
  localparam logic [2:0] REG_C = 3'h2;
  localparam logic [2:0] REG_B = 3'h3;
  localparam logic [1:0] ACCUMULATOR_PAIR = 2'h0;
  localparam logic [1:0] POINTER_PAIR     = 2'h2;
  localparam logic [1:0] BASE_PAIR        = 2'h3;
  localparam int         REG_COUNT        = 8;
  localparam int         BANK_COUNT       = 4;
  // ****************************************
  // Address windows
  // ****************************************
  localparam logic [6:0]  SHORT_TOP      = 7'h7f;
  localparam logic [7:0]  SHORT_SPLIT    = 8'h20;
  localparam logic [7:0]  SFR_PAGE       = 8'hff;
  localparam logic [7:0]  SFR_GAP_LO     = 8'hd0;
  localparam logic [7:0]  SFR_GAP_HI     = 8'hdf;
  localparam logic [15:0] RAM_WIN_LO     = 16'hfe20;
  localparam logic [15:0] RAM_WIN_HI     = 16'hfeff;
  localparam logic [15:0] SFR_WIN_LO     = 16'hff00;
  localparam logic [15:0] SFR_WIN_HI     = 16'hff1f;
  localparam logic [15:0] HSRAM_LO_DFLT  = 16'hfb00;
  localparam logic [15:0] HSRAM_HI_DFLT  = 16'hfeff;
  localparam logic [7:0]  OPC_LOAD_BASE_B = 8'hab;
  // ****************************************
  // Modes, implied operations, carriers
  // ****************************************
  typedef enum logic [3:0] {
    MODE_NONE = 4'h0, MODE_IMPLIED = 4'h1, MODE_REG8 = 4'h2,
    MODE_REG16 = 4'h3, MODE_DIRECT = 4'h4, MODE_SHORT = 4'h5,
    MODE_SFR = 4'h6, MODE_INDIRECT = 4'h7, MODE_BASED = 4'h8,
    MODE_BASED_IDX = 4'h9, MODE_STACK = 4'ha, MODE_OPCODE = 4'hb
  } mode_type;
  typedef enum logic [2:0] {
    UNSIGNED_BYTE_MULTIPLY = 3'h0, UNSIGNED_WORD_DIVIDE = 3'h1,
    DECIMAL_ADJUST_AFTER_ADD = 3'h2, DECIMAL_ADJUST_AFTER_SUB = 3'h3,
    NIBBLE_ROTATE_RIGHT = 3'h4, NIBBLE_ROTATE_LEFT = 3'h5
  } implied_type;
  typedef enum logic [1:0] {
    KIND_NONE = 2'h0, KIND_MEM = 2'h1, KIND_REG = 2'h2
  } kind_type;
  typedef struct packed {
    logic        valid;
    mode_type    mode;
    implied_type op;
    logic [2:0]  reg_code;
    logic        index_high;
    logic [7:0]  imm8;
    logic [15:0] absolute_address_field;
    logic [7:0]  opcode;
  } req_type;
  typedef struct packed {
    logic        valid;
    logic        pair;
    logic [2:0]  reg_code;
    logic [15:0] data;
  } wr_type;
  typedef struct packed {
    logic        valid;
    mode_type    mode;
    kind_type    kind;
    logic [15:0] addr;
    logic [4:0]  reg_index;
    logic [4:0]  src_index;
    logic        is_pair;
    logic        src_pair;
    logic        in_ram_window;
    logic        in_sfr_window;
    logic        unreachable;
    logic        stack_fault;
  } result_type;
endpackage

//--- src/window_mapper.sv
// Short direct and special-register window address mapping
`timescale 1ns/1ps
`default_nettype none
module window_mapper
  import oag_pkg::*;
(
  input  wire logic [7:0]  imm8,
  output logic      [15:0] short_ea,
  output logic      [15:0] sfr_ea,
  output logic             sfr_gap,
  output logic             in_ram,
  output logic             in_sfr
);
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction
  // ****************************************
  // Window decode
  // ****************************************
  wire bit8 = (imm8 < SHORT_SPLIT);
  assign short_ea = {SHORT_TOP, bit8, imm8};
  assign sfr_ea   = {SFR_PAGE, imm8};
  assign sfr_gap  = (imm8 >= SFR_GAP_LO) && (imm8 <= SFR_GAP_HI);
  assign in_ram   = in_range(short_ea, RAM_WIN_LO, RAM_WIN_HI);
  assign in_sfr   = in_range(short_ea, SFR_WIN_LO, SFR_WIN_HI);
endmodule
`default_nettype wire

//--- src/reg_bank_file.sv
// Banked general register file, current bank exposed as a flat view
`timescale 1ns/1ps
`default_nettype none
module reg_bank_file
  import oag_pkg::*;
#(
  parameter int BANKS = BANK_COUNT,
  parameter int REGS  = REG_COUNT
)(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [1:0]             bank,
  input  wire wr_type                 wr,
  output wire logic [REGS*8-1:0]      view
);
  if (BANKS != 4 || REGS != 8) begin : g_bad_size
    $error("reg_bank_file supports four banks of eight bytes only");
  end
  logic [7:0] regs [BANKS*REGS];
  wire  [4:0] base = {bank, 3'h0};
  wire  [4:0] lo_i = wr.pair ? {bank, wr.reg_code[1:0], 1'b0}
                             : {bank, wr.reg_code};
  wire  [4:0] hi_i = {bank, wr.reg_code[1:0], 1'b1};
  // ****************************************
  // Storage and bank view
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < BANKS*REGS; i++) regs[i] <= 8'h00;
    end else if (wr.valid) begin
      regs[lo_i] <= wr.data[7:0];
      if (wr.pair) regs[hi_i] <= wr.data[15:8];
    end
  end
  for (genvar g = 0; g < REGS; g++) begin : g_view
    assign view[g*8 +: 8] = regs[base + 5'(g)];
  end
endmodule
`default_nettype wire

//--- src/operand_address_generator.sv
// Operand effective-address generator for the 8-bit core
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Multiply: source A, product into accumulator pair
// - Divide: dividend and quotient in accumulator pair
// - Decimal adjust operates implicitly on A
// - Nibble rotate holds digits in A
// - Bank flags plus opcode code locate register
// - Three-bit byte code; two-bit pair code
// - Direct: 16-bit field used unchanged
// - Short direct reaches FE20H..FF1FH only
// - Address bit 8 set below 20H
// - Window splits into RAM and SFRs
// - SFR mode skips FFD0H..FFDFH gap
// - Indirect uses banked pointer or base pair
// - Based: base pair plus zero-extended byte
// - Based indexed: base pair plus B or C
// - Opcode ABH loads A from base pair plus B
// - Stack accesses confined to high-speed RAM
module operand_address_generator
  import oag_pkg::*;
#(
  parameter logic [15:0] HSRAM_LO = HSRAM_LO_DFLT,
  parameter logic [15:0] HSRAM_HI = HSRAM_HI_DFLT
)(
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        BANK_SELECT_BIT0,
  input  wire logic        BANK_SELECT_BIT1,
  input  wire req_type     REQ,
  input  wire wr_type      REG_WR,
  input  wire logic [15:0] SP,
  output var result_type   RESULT
);
  if (HSRAM_LO > HSRAM_HI) begin : g_bad_hsram
    $error("High-speed RAM bounds are reversed");
  end
  // ****************************************
  // Bank view and window decode
  // ****************************************
  wire [1:0]  bank = {BANK_SELECT_BIT1, BANK_SELECT_BIT0};
  wire [63:0] view;
  wire [15:0] short_ea;
  wire [15:0] sfr_ea;
  wire        sfr_gap;
  wire        in_ram;
  wire        in_sfr;

  reg_bank_file #(
    .BANKS (BANK_COUNT),
    .REGS  (REG_COUNT)
  ) u_regs (
    .clk  (REF_CLK),
    .rst  (SYS_RST),
    .bank (bank),
    .wr   (REG_WR),
    .view (view)
  );

  window_mapper u_win (
    .imm8     (REQ.imm8),
    .short_ea (short_ea),
    .sfr_ea   (sfr_ea),
    .sfr_gap  (sfr_gap),
    .in_ram   (in_ram),
    .in_sfr   (in_sfr)
  );

  function automatic logic [7:0] byte_of(input logic [63:0] v,
                                         input logic [2:0] code);
    byte_of = v[{code, 3'h0} +: 8];
  endfunction
  function automatic logic [15:0] pair_of(input logic [63:0] v,
                                          input logic [1:0] p);
    pair_of = {byte_of(v, {p, 1'b1}), byte_of(v, {p, 1'b0})};
  endfunction
  function automatic logic [4:0] byte_idx(input logic [1:0] b,
                                          input logic [2:0] code);
    byte_idx = {b, code};
  endfunction
  function automatic logic [4:0] pair_idx(input logic [1:0] b,
                                          input logic [1:0] p);
    pair_idx = {b, p, 1'b0};
  endfunction
  // ****************************************
  // Address arithmetic
  // ****************************************
  wire [15:0] base_val    = pair_of(view, BASE_PAIR);
  wire [15:0] pointer_val = pair_of(view, POINTER_PAIR);
  wire        use_ptr     = (REQ.reg_code[1:0] == POINTER_PAIR);
  wire [15:0] ptr         = use_ptr ? pointer_val : base_val;
  wire [7:0]  idx_b       = byte_of(view, REG_B);
  wire [7:0]  idx_c       = byte_of(view, REG_C);
  wire [7:0]  idx         = REQ.index_high ? idx_b : idx_c;
  // Carry out of bit 15 is dropped so the address wraps
  wire [16:0] based_s     = {1'b0, base_val} + {9'h000, REQ.imm8};
  wire [16:0] index_s     = {1'b0, base_val} + {9'h000, idx};
  wire [16:0] base_b_s    = {1'b0, base_val} + {9'h000, idx_b};
  wire [15:0] based_ea    = based_s[15:0];
  wire [15:0] index_ea    = index_s[15:0];
  wire [15:0] base_b_ea   = base_b_s[15:0];
  wire        opc_base_b  = (REQ.opcode == OPC_LOAD_BASE_B);
  wire        sp_ok       = (SP >= HSRAM_LO) && (SP <= HSRAM_HI);
  wire [4:0]  a_idx       = byte_idx(bank, REG_A);
  wire [4:0]  acc_idx     = pair_idx(bank, ACCUMULATOR_PAIR);
  // ****************************************
  // Result selection
  // ****************************************
  result_type next_result;
  always_comb begin
    next_result          = '0;
    next_result.valid    = REQ.valid;
    next_result.mode     = REQ.mode;
    next_result.kind     = KIND_NONE;
    if (REQ.valid) begin
      case (REQ.mode)
        MODE_IMPLIED: begin
          next_result.kind      = KIND_REG;
          next_result.src_index = a_idx;
          next_result.reg_index = a_idx;
          case (REQ.op)
            UNSIGNED_BYTE_MULTIPLY: begin
              next_result.reg_index = acc_idx;
              next_result.is_pair   = 1'b1;
            end
            UNSIGNED_WORD_DIVIDE: begin
              next_result.src_index = acc_idx;
              next_result.reg_index = acc_idx;
              next_result.src_pair  = 1'b1;
              next_result.is_pair   = 1'b1;
            end
            DECIMAL_ADJUST_AFTER_ADD,
            DECIMAL_ADJUST_AFTER_SUB: begin
              next_result.reg_index = a_idx;
            end
            NIBBLE_ROTATE_RIGHT,
            NIBBLE_ROTATE_LEFT: begin
              next_result.reg_index = a_idx;
            end
            default: begin
              next_result.kind = KIND_NONE;
            end
          endcase
        end
        MODE_REG8: begin
          next_result.kind      = KIND_REG;
          next_result.reg_index = byte_idx(bank, REQ.reg_code);
        end
        MODE_REG16: begin
          next_result.kind      = KIND_REG;
          next_result.is_pair   = 1'b1;
          next_result.reg_index = pair_idx(bank, REQ.reg_code[1:0]);
        end
        MODE_DIRECT: begin
          next_result.kind = KIND_MEM;
          next_result.addr = REQ.absolute_address_field;
        end
        MODE_SHORT: begin
          next_result.kind          = KIND_MEM;
          next_result.addr          = short_ea;
          next_result.in_ram_window = in_ram;
          next_result.in_sfr_window = in_sfr;
        end
        MODE_SFR: begin
          // Gap addresses are flagged and produce no access
          next_result.kind        = sfr_gap ? KIND_NONE : KIND_MEM;
          next_result.addr        = sfr_ea;
          next_result.unreachable = sfr_gap;
        end
        MODE_INDIRECT: begin
          next_result.kind = KIND_MEM;
          next_result.addr = ptr;
        end
        MODE_BASED: begin
          next_result.kind = KIND_MEM;
          next_result.addr = based_ea;
        end
        MODE_BASED_IDX: begin
          next_result.kind = KIND_MEM;
          next_result.addr = index_ea;
        end
        MODE_STACK: begin
          next_result.kind        = sp_ok ? KIND_MEM : KIND_NONE;
          next_result.addr        = SP;
          next_result.stack_fault = !sp_ok;
        end
        MODE_OPCODE: begin
          if (opc_base_b) begin
            next_result.kind      = KIND_MEM;
            next_result.mode      = MODE_BASED_IDX;
            next_result.addr      = base_b_ea;
            next_result.reg_index = a_idx;
          end else begin
            next_result.unreachable = 1'b1;
          end
        end
        default: begin
          next_result.unreachable = 1'b1;
        end
      endcase
    end
  end
  // ****************************************
  // Output register
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) RESULT <= '0;
    else         RESULT <= next_result;
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  wire req_imp = REQ.valid && REQ.mode == MODE_IMPLIED;

  property p_mul;
    req_imp && REQ.op == UNSIGNED_BYTE_MULTIPLY |=>
      RESULT.is_pair && RESULT.reg_index == {$past(bank), 3'h0}
      && RESULT.src_index == {$past(bank), REG_A};
  endproperty
  a_mul: assert property (p_mul) else $error("Multiply operands wrong");

  property p_div;
    req_imp && REQ.op == UNSIGNED_WORD_DIVIDE |=>
      RESULT.src_pair && RESULT.src_index == RESULT.reg_index
      && RESULT.reg_index[2:0] == 3'h0;
  endproperty
  a_div: assert property (p_div) else $error("Divide pair wrong");

  property p_adj;
    req_imp && (REQ.op == DECIMAL_ADJUST_AFTER_ADD || REQ.op == NIBBLE_ROTATE_LEFT)
      |=> !RESULT.is_pair && RESULT.reg_index == {$past(bank), REG_A};
  endproperty
  a_adj: assert property (p_adj) else $error("Accumulator not implied");

  property p_reg8;
    REQ.valid && REQ.mode == MODE_REG8 |=>
      RESULT.kind == KIND_REG && RESULT.reg_index == {$past(bank), $past(REQ.reg_code)};
  endproperty
  a_reg8: assert property (p_reg8) else $error("Byte register index wrong");

  property p_direct;
    REQ.valid && REQ.mode == MODE_DIRECT |=>
      RESULT.addr == $past(REQ.absolute_address_field) && RESULT.kind == KIND_MEM;
  endproperty
  a_direct: assert property (p_direct) else $error("Direct address altered");

  property p_short;
    REQ.valid && REQ.mode == MODE_SHORT |=>
      RESULT.addr[8] == ($past(REQ.imm8) < 8'h20) && RESULT.addr[15:9] == 7'h7f
      && RESULT.addr[7:0] == $past(REQ.imm8) && RESULT.in_ram_window == !RESULT.addr[8];
  endproperty
  a_short: assert property (p_short) else $error("Short direct address wrong");

  property p_sfr;
    REQ.valid && REQ.mode == MODE_SFR |=>
      RESULT.unreachable == (RESULT.addr[7:4] == 4'hd)
      && RESULT.addr[15:8] == 8'hff;
  endproperty
  a_sfr: assert property (p_sfr) else $error("Special register gap wrong");

  property p_based;
    REQ.valid && REQ.mode == MODE_BASED |=>
      RESULT.addr == 16'($past(base_val) + {8'h00, $past(REQ.imm8)});
  endproperty
  a_based: assert property (p_based) else $error("Based address wrong");

  property p_bidx;
    REQ.valid && REQ.mode == MODE_BASED_IDX |=>
      RESULT.addr == 16'($past(base_val) + {8'h00, $past(REQ.index_high ? idx_b : idx_c)});
  endproperty
  a_bidx: assert property (p_bidx) else $error("Based indexed address wrong");

  property p_ind;
    REQ.valid && REQ.mode == MODE_INDIRECT |=>
      RESULT.addr == (($past(REQ.reg_code[1:0]) == 2'h2) ? $past(pointer_val) : $past(base_val));
  endproperty
  a_ind: assert property (p_ind) else $error("Indirect pointer wrong");

  property p_opc;
    REQ.valid && REQ.mode == MODE_OPCODE && REQ.opcode == 8'hab |=>
      RESULT.addr == 16'($past(base_val) + {8'h00, $past(idx_b)}) && RESULT.kind == KIND_MEM;
  endproperty
  a_opc: assert property (p_opc) else $error("Opcode ABH misdecoded");

  property p_stack;
    REQ.valid && REQ.mode == MODE_STACK |=>
      RESULT.stack_fault == ($past(SP) < HSRAM_LO || $past(SP) > HSRAM_HI)
      && (RESULT.kind == KIND_MEM) == !RESULT.stack_fault;
  endproperty
  a_stack: assert property (p_stack) else $error("Stack confinement broken");

  c_wrap:  cover property (REQ.valid && REQ.mode == MODE_BASED ##1 RESULT.addr < base_val);
  c_sfrw:  cover property (RESULT.valid && RESULT.in_sfr_window);
  c_fault: cover property (RESULT.stack_fault);
  c_bank3: cover property (REQ.valid && bank == 2'h3 ##1 RESULT.kind == KIND_REG);
endmodule
`default_nettype wire

//--- dv/mem_bus_model.sv
// Behavioural model of the internal memory and special-register bus
`timescale 1ns/1ps
`default_nettype none
module mem_bus_model
  import oag_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire result_type res,
  output logic      [7:0] rd_data
);
  // ****************************************
  // Storage and read port
  // ****************************************
  logic [7:0] idle_pattern;
  // Each location reads back a pattern made from its own address
  // Callers keep word operands on even addresses
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_pattern <= 8'h5a;
      rd_data      <= 8'h00;
    end else begin
      idle_pattern <= ~idle_pattern;
      // Nothing selected: the bus shows a changing pattern, never stale data
      rd_data <= (res.valid && res.kind == KIND_MEM) ? (res.addr[15:8] ^ res.addr[7:0])
                                                     : idle_pattern;
    end
  end
endmodule
`default_nettype wire

//--- dv/operand_address_generator_tb.sv
// Self-checking testbench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator_tb;
  import oag_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic       ref_clk;
  logic       sys_rst;
  logic [1:0] bank;
  req_type    req;
  wr_type     reg_wr;
  logic [15:0] sp;
  result_type result;
  logic [7:0] bus_data;
  logic [7:0] sh [4][8];
  int         errors;
  int         n_compared;
  int         cycles = 0;
  logic       bus_mem;
  logic [15:0] bus_addr;
  int         seed;
  req_type    pend_req;
  result_type pend;
  operand_address_generator #(.HSRAM_LO(HSRAM_LO_DFLT), .HSRAM_HI(HSRAM_HI_DFLT))
    u_operand_address_generator (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .BANK_SELECT_BIT0(bank[0]),
    .BANK_SELECT_BIT1(bank[1]), .REQ(req), .REG_WR(reg_wr), .SP(sp), .RESULT(result));
  mem_bus_model u_mem_bus_model (.clk(ref_clk), .rst(sys_rst), .res(result), .rd_data(bus_data));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ****************************************
  // Reporting
  // ****************************************
  task automatic final_report();
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // A hang past this ceiling is far beyond the fewer than a thousand cycles the run needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // ****************************************
  // Expectation
  // ****************************************
  function automatic result_type expect_of(req_type r, logic [1:0] b, logic [15:0] s);
    result_type e;
    logic [15:0] base_val;
    logic [15:0] pointer_val;
    e = '0;
    e.valid = r.valid;
    e.mode = r.mode;
    base_val = {sh[b][7], sh[b][6]};
    pointer_val = {sh[b][5], sh[b][4]};
    if (!r.valid) return e;
    e.kind = KIND_MEM;
    case (r.mode)
      MODE_IMPLIED: begin
        e.kind = KIND_REG;
        e.is_pair = (r.op == UNSIGNED_BYTE_MULTIPLY || r.op == UNSIGNED_WORD_DIVIDE);
        e.reg_index = e.is_pair ? {b, ACCUMULATOR_PAIR, 1'b0} : {b, REG_A};
        e.src_pair = (r.op == UNSIGNED_WORD_DIVIDE);
        e.src_index = e.src_pair ? {b, ACCUMULATOR_PAIR, 1'b0} : {b, REG_A};
      end
      MODE_REG8: begin
        e.kind = KIND_REG;
        e.reg_index = {b, r.reg_code};
      end
      MODE_REG16: begin
        e.kind = KIND_REG;
        e.is_pair = 1'b1;
        e.reg_index = {b, r.reg_code[1:0], 1'b0};
      end
      MODE_DIRECT: e.addr = r.absolute_address_field;
      MODE_SHORT: begin
        e.addr = {7'h7f, r.imm8 < 8'h20, r.imm8};
        e.in_ram_window = (e.addr <= RAM_WIN_HI);
        e.in_sfr_window = (e.addr >= SFR_WIN_LO);
      end
      MODE_SFR: begin
        e.addr = {8'hff, r.imm8};
        if (r.imm8 >= 8'hd0 && r.imm8 <= 8'hdf) begin
          e.addr = '0;
          e.kind = KIND_NONE;
          e.unreachable = 1'b1;
        end
      end
      MODE_INDIRECT: e.addr = (r.reg_code[1:0] == POINTER_PAIR) ? pointer_val : base_val;
      MODE_BASED: e.addr = base_val + {8'h00, r.imm8};
      MODE_BASED_IDX: e.addr = base_val + {8'h00, r.index_high ? sh[b][3] : sh[b][2]};
      MODE_OPCODE: begin
        if (r.opcode == 8'hab) begin
          e.mode = MODE_BASED_IDX;
          e.addr = base_val + {8'h00, sh[b][3]};
          e.reg_index = {b, REG_A};
        end else begin
          e.kind = KIND_NONE;
          e.unreachable = 1'b1;
        end
      end
      MODE_STACK: begin
        e.addr = s;
        if (s < HSRAM_LO_DFLT || s > HSRAM_HI_DFLT) begin
          e.kind = KIND_NONE;
          e.stack_fault = 1'b1;
        end
      end
      default: begin
        e.kind = KIND_NONE;
        e.unreachable = 1'b1;
      end
    endcase
    return e;
  endfunction
  // ****************************************
  // Driving and comparing
  // ****************************************
  task automatic compare(req_type r, result_type e);
    check("valid", result.valid, e.valid);
    if (e.valid) begin
      check("mode", result.mode, e.mode);
      check("kind", result.kind, e.kind);
      check("unreachable", result.unreachable, e.unreachable);
      check("stack_fault", result.stack_fault, e.stack_fault);
      if (e.kind == KIND_MEM)
        check("addr", result.addr, e.addr);
      if (e.kind != KIND_NONE) begin
        check("reg_index", result.reg_index, e.reg_index);
        check("is_pair", result.is_pair, e.is_pair);
      end
      if (r.mode == MODE_IMPLIED) begin
        check("src_index", result.src_index, e.src_index);
        check("src_pair", result.src_pair, e.src_pair);
      end
      if (r.mode == MODE_SHORT) begin
        check("in_ram", result.in_ram_window, e.in_ram_window);
        check("in_sfr", result.in_sfr_window, e.in_sfr_window);
      end
    end
  endtask
  // The request sees register contents from before a write driven with it
  task automatic step(req_type r, wr_type w, logic [1:0] b, logic [15:0] s);
    result_type e;
    @(posedge ref_clk);
    req <= r;
    reg_wr <= w;
    bank <= b;
    sp <= s;
    e = expect_of(r, b, s);
    if (w.valid && w.pair) begin
      sh[b][{w.reg_code[1:0], 1'b0}] = w.data[7:0];
      sh[b][{w.reg_code[1:0], 1'b1}] = w.data[15:8];
    end else if (w.valid) begin
      sh[b][w.reg_code] = w.data[7:0];
    end
    @(negedge ref_clk);
    // The bus model answers one cycle after the result it was shown
    if (bus_mem) check("bus_data", bus_data, 32'(bus_addr[15:8] ^ bus_addr[7:0]));
    bus_mem = pend.valid && pend.kind == KIND_MEM;
    bus_addr = pend.addr;
    compare(pend_req, pend);
    pend_req = r;
    pend = e;
  endtask
  function automatic req_type mk(mode_type m, logic [7:0] imm, logic [2:0] code = 3'h0,
                                 logic ih = 1'b0, logic [7:0] opc = 8'h00,
                                 implied_type op = UNSIGNED_BYTE_MULTIPLY);
    return '{1'b1, m, op, code, ih, imm, 16'hfe00, opc};
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  logic [7:0]  short_imm [9] = '{8'h00, 8'h1f, 8'h20, 8'hff, 8'hcf, 8'hd0, 8'hdf, 8'he0, 8'h7e};
  logic [15:0] sp_list   [4] = '{16'hfaff, 16'hfb00, 16'hfeff, 16'hff00};
  logic [31:0] rnd;
  initial begin
    seed = 32'hc2ae;
    errors = 0;
    n_compared = 0;
    bus_mem = 1'b0;
    bus_addr = 16'h0000;
    sys_rst = 1'b1;
    bank = 2'h0;
    req = '0;
    reg_wr = '0;
    sp = 16'h0000;
    pend = '0;
    pend_req = '0;
    foreach (sh[i, j]) sh[i][j] = 8'h00;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      rnd = $random(seed);
      step('0, '{1'b1, 1'b1, 3'h3, 16'hfff0 + 16'(b)}, 2'(b), 16'h0000);
      step('0, '{1'b1, 1'b1, 3'h1, rnd[15:0]}, 2'(b), 16'h0000);
      step('0, '{1'b1, 1'b1, 3'h2, rnd[31:16]}, 2'(b), 16'h0000);
    end
    for (int b = 0; b < 4; b++) begin
      for (int i = 0; i < 9; i++) begin
        step(mk(i < 4 ? MODE_SHORT : MODE_SFR, short_imm[i]), '0, 2'(b), 16'h0000);
        step(mk(MODE_SFR, short_imm[i]), '0, 2'(b), 16'h0000);
      end
      step(mk(MODE_BASED, 8'hff), '0, 2'(b), 16'h0000);
      step(mk(MODE_BASED_IDX, 8'h00, 3'h0, 1'b0), '0, 2'(b), 16'h0000);
      step(mk(MODE_BASED_IDX, 8'h00, 3'h0, 1'b1), '0, 2'(b), 16'h0000);
      step(mk(MODE_OPCODE, 8'h00, 3'h0, 1'b0, 8'hab), '0, 2'(b), 16'h0000);
      step(mk(MODE_OPCODE, 8'h00, 3'h0, 1'b0, 8'haa), '0, 2'(b), 16'h0000);
      step(mk(MODE_INDIRECT, 8'h00, 3'h2), '0, 2'(b), 16'h0000);
      step(mk(MODE_INDIRECT, 8'h00, 3'h3), '0, 2'(b), 16'h0000);
      step(mk(MODE_DIRECT, 8'h00), '0, 2'(b), 16'h0000);
      step(mk(MODE_REG8, 8'h00, 3'h7), '0, 2'(b), 16'h0000);
      step(mk(MODE_REG16, 8'h00, 3'h2), '0, 2'(b), 16'h0000);
      step(mk(mode_type'(4'hc), 8'h00), '0, 2'(b), 16'h0000);
      for (int k = 0; k < 6; k++)
        step(mk(MODE_IMPLIED, 8'h00, 3'h0, 1'b0, 8'h00, implied_type'(k)), '0, 2'(b), 16'h0);
      for (int k = 0; k < 4; k++)
        step(mk(MODE_STACK, 8'h00), '0, 2'(b), sp_list[k]);
    end
    // Random traffic, back to back, with writes mixed in
    for (int n = 0; n < 600; n++) begin
      req_type r;
      wr_type  w;
      rnd = $random(seed);
      r = mk(mode_type'(4'(($unsigned($random(seed)) % 12) + 1)), rnd[7:0], rnd[10:8],
             rnd[11], rnd[19:12], implied_type'(3'($unsigned($random(seed)) % 6)));
      r.valid = rnd[20] | rnd[21];
      r.absolute_address_field = 16'($random(seed));
      rnd = $random(seed);
      w = '{rnd[0], rnd[1], rnd[1] ? {1'b0, rnd[3:2]} : rnd[4:2], rnd[31:16]};
      step(r, w, rnd[6:5], {5'h1f, rnd[15:5]});
    end
    step('0, '0, 2'h0, 16'h0000);
    // Reset in mid-run clears the output and the register file
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("reset_result", 32'(result != '0), 32'h0000_0000);
    foreach (sh[i, j]) sh[i][j] = 8'h00;
    bus_mem = 1'b0;
    pend = '0;
    pend_req = '0;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    step(mk(MODE_BASED, 8'h5a), '0, 2'h3, 16'h0000);
    step(mk(MODE_BASED, 8'h00), '0, 2'h1, 16'h0000);
    step('0, '0, 2'h0, 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
